// ===== rtl/fpc_top.v
// fractional pll configuration registers, reference predivider, settling timer and master clock select
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "fpc_map.vh"

module fpc_top #(
    parameter SETTLE_CYCLES = `FPC_SETTLE_CYCLES,
    parameter TIMER_W = 16
) (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire ref_clk_i,
    output reg mclk_en_o,
    output reg pll_power_o,
    output reg [7:0] cal_ratio_o,
    output reg pll_settled_o
);
    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    reg master_clock_source_select;
    reg pll_start;
    reg [1:0] reference_predivider;
    reg [7:0] pll_int_factor;
    reg [7:0] frac_lo;
    reg [7:0] frac_mid;
    reg [7:0] frac_hi;
    reg [1:0] pll_mode;
    reg [7:0] pll_output_divider;
    reg [7:0] pll_cal_ratio;
    reg [7:0] next_rdata;

    // ----------------------------------------------------------------
    // reference path and timer state
    // ----------------------------------------------------------------
    wire ref_level;
    wire ref_rise;
    reg [2:0] pre_cnt;
    reg pre_tick;
    reg [TIMER_W-1:0] settle_cnt;
    reg settled;
    wire synth_tick;
    wire [31:0] mult;
    wire [2:0] pre_last;

    localparam integer SETTLE_LAST_I = SETTLE_CYCLES - 1;
    localparam [TIMER_W-1:0] SETTLE_LAST = SETTLE_LAST_I[TIMER_W-1:0];
    localparam [7:0] RST_CTRL = `FPC_RST_CTRL;

    // ----------------------------------------------------------------
    // predivider decode
    // ----------------------------------------------------------------
    function [2:0] fpc_prediv_last;
        input [1:0] code;
        begin
            case (code)
                `FPC_PREDIV_DIV1: fpc_prediv_last = 3'h0;
                `FPC_PREDIV_DIV2: fpc_prediv_last = 3'h1;
                `FPC_PREDIV_DIV4: fpc_prediv_last = 3'h3;
                default: fpc_prediv_last = 3'h7;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            master_clock_source_select <= RST_CTRL[`FPC_CTRL_SRC_BIT];
            pll_start <= 1'b0;
            reference_predivider <= `FPC_RST_PREDIV;
            pll_int_factor <= `FPC_RST_INT;
            frac_lo <= `FPC_RST_FRAC;
            frac_mid <= `FPC_RST_FRAC;
            frac_hi <= `FPC_RST_FRAC;
            pll_mode <= `FPC_RST_MODE;
            pll_output_divider <= `FPC_RST_DIVOUT;
            pll_cal_ratio <= `FPC_RST_CAL;
        end else if (wr_i) begin
            case (addr_i)
                `FPC_ADDR_CTRL: begin
                    master_clock_source_select <= wdata_i[`FPC_CTRL_SRC_BIT];
                    pll_start <= wdata_i[`FPC_CTRL_START_BIT];
                end
                `FPC_ADDR_PREDIV: reference_predivider <= wdata_i[1:0];
                `FPC_ADDR_INT: pll_int_factor <= wdata_i;
                `FPC_ADDR_FRAC_LO: frac_lo <= wdata_i;
                `FPC_ADDR_FRAC_MID: frac_mid <= wdata_i;
                `FPC_ADDR_FRAC_HI: frac_hi <= wdata_i;
                `FPC_ADDR_MODE: pll_mode <= wdata_i[1:0];
                // divider may be rewritten while running, so the scaled start value can be restored
                `FPC_ADDR_DIVOUT: pll_output_divider <= wdata_i;
                `FPC_ADDR_CAL: pll_cal_ratio <= wdata_i;
                default: pll_start <= pll_start;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // register reads, data valid only in the cycle after the strobe
    // ----------------------------------------------------------------
    always @* begin
        next_rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                `FPC_ADDR_CTRL: begin
                    next_rdata[`FPC_CTRL_SRC_BIT] = master_clock_source_select;
                    next_rdata[`FPC_CTRL_START_BIT] = pll_start;
                end
                `FPC_ADDR_PREDIV: next_rdata = {6'h00, reference_predivider};
                `FPC_ADDR_INT: next_rdata = pll_int_factor;
                `FPC_ADDR_FRAC_LO: next_rdata = frac_lo;
                `FPC_ADDR_FRAC_MID: next_rdata = frac_mid;
                `FPC_ADDR_FRAC_HI: next_rdata = frac_hi;
                `FPC_ADDR_MODE: next_rdata = {6'h00, pll_mode};
                `FPC_ADDR_DIVOUT: next_rdata = pll_output_divider;
                `FPC_ADDR_CAL: next_rdata = pll_cal_ratio;
                `FPC_ADDR_STATUS: begin
                    next_rdata[`FPC_STAT_SETTLED_BIT] = settled;
                    next_rdata[`FPC_STAT_RUNNING_BIT] = pll_start;
                end
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // reference pin, shared by serial port and two-wire bus clocks
    // ----------------------------------------------------------------
    // limitation: the pin is sampled, so references above half the system clock alias
    fpc_sync u_ref_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(ref_clk_i),
        .level_o(ref_level),
        .rise_o(ref_rise)
    );

    // ----------------------------------------------------------------
    // reference predivider
    // ----------------------------------------------------------------
    assign pre_last = fpc_prediv_last(reference_predivider);

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_cnt <= 3'h0;
            pre_tick <= 1'b0;
        end else if (!pll_start) begin
            pre_cnt <= 3'h0;
            pre_tick <= 1'b0;
        end else if (ref_rise) begin
            if (pre_cnt >= pre_last) begin
                pre_cnt <= 3'h0;
                pre_tick <= 1'b1;
            end else begin
                pre_cnt <= pre_cnt + 3'h1;
                pre_tick <= 1'b0;
            end
        end else begin
            pre_tick <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // multiplier and output divider
    // ----------------------------------------------------------------
    assign mult = {pll_int_factor, frac_hi, frac_mid, frac_lo};

    fpc_synth #(
        .FRAC_W(24),
        .CREDIT_W(40)
    ) u_synth (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .run_i(pll_start),
        .ref_tick_i(pre_tick),
        .mult_i(mult),
        .mode_i(pll_mode),
        .div_i(pll_output_divider),
        .tick_o(synth_tick)
    );

    // ----------------------------------------------------------------
    // settling timer after start
    // ----------------------------------------------------------------
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            settle_cnt <= {TIMER_W{1'b0}};
            settled <= 1'b0;
        end else if (!pll_start) begin
            settle_cnt <= {TIMER_W{1'b0}};
            settled <= 1'b0;
        end else if (!settled) begin
            if (settle_cnt == SETTLE_LAST) begin
                settled <= 1'b1;
            end else begin
                settle_cnt <= settle_cnt + {{(TIMER_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // ----------------------------------------------------------------
    // master clock select and outputs
    // ----------------------------------------------------------------
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mclk_en_o <= 1'b0;
            pll_power_o <= 1'b0;
            cal_ratio_o <= `FPC_RST_CAL;
            pll_settled_o <= 1'b0;
        end else begin
            if (!master_clock_source_select) begin
                mclk_en_o <= ref_rise;
            end else begin
                // an unsettled pll would hand out a wandering clock, so it stays quiet
                mclk_en_o <= synth_tick & settled & pll_start;
            end
            pll_power_o <= pll_start;
            cal_ratio_o <= pll_cal_ratio;
            pll_settled_o <= settled;
        end
    end
endmodule

// ===== rtl/fpc_map.vh
// register map, field positions, reset values and timing counts of the fractional pll clock control
`ifndef FPC_MAP_VH
`define FPC_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define FPC_ADDR_CTRL 8'h00
`define FPC_ADDR_PREDIV 8'h01
`define FPC_ADDR_INT 8'h02
`define FPC_ADDR_FRAC_LO 8'h03
`define FPC_ADDR_FRAC_MID 8'h04
`define FPC_ADDR_FRAC_HI 8'h05
`define FPC_ADDR_MODE 8'h06
`define FPC_ADDR_DIVOUT 8'h07
`define FPC_ADDR_CAL 8'h08
`define FPC_ADDR_STATUS 8'h09

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FPC_CTRL_SRC_BIT 0
`define FPC_CTRL_START_BIT 1
`define FPC_STAT_SETTLED_BIT 0
`define FPC_STAT_RUNNING_BIT 1

// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define FPC_PREDIV_DIV1 2'h0
`define FPC_PREDIV_DIV2 2'h1
`define FPC_PREDIV_DIV4 2'h2
`define FPC_PREDIV_DIV8 2'h3
`define FPC_MODE_BYPASS_BOTH 2'h3
`define FPC_RST_CTRL 8'h00
`define FPC_RST_PREDIV 2'h0
`define FPC_RST_INT 8'h40
`define FPC_RST_FRAC 8'h00
`define FPC_RST_MODE 2'h3
`define FPC_RST_DIVOUT 8'h10
`define FPC_RST_CAL 8'h80

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FPC_SETTLE_US 800
`define FPC_CLK_MHZ 10
`define FPC_SETTLE_CYCLES (`FPC_SETTLE_US * `FPC_CLK_MHZ)

`endif

// ===== rtl/fpc_sync.v
// two-stage synchroniser with rising edge pulse for the reference clock pin
`timescale 1ns/1ps
module fpc_sync (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire async_i,
    output wire level_o,
    output wire rise_o
);
    reg meta;
    reg stable;
    reg prev;

    // only the second stage and later are looked at
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= 1'b0;
            stable <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= async_i;
            stable <= meta;
            prev <= stable;
        end
    end

    assign level_o = stable;
    assign rise_o = stable & ~prev;
endmodule

// ===== rtl/fpc_synth.v
// fractional-n rate synthesiser: credits vco cycles per reference tick, drains them by the output divider
`timescale 1ns/1ps
module fpc_synth #(
    parameter FRAC_W = 24,
    parameter CREDIT_W = 40
) (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire run_i,
    input wire ref_tick_i,
    input wire [FRAC_W+7:0] mult_i,
    input wire [1:0] mode_i,
    input wire [7:0] div_i,
    output reg tick_o
);
    reg [CREDIT_W-1:0] credit;
    reg [CREDIT_W-1:0] next_credit;
    reg next_tick;
    wire [CREDIT_W-1:0] eff;
    wire [CREDIT_W-1:0] thr;
    wire [CREDIT_W-1:0] sum;

    // ----------------------------------------------------------------
    // mode factor: a cleared bit applies its factor
    // ----------------------------------------------------------------
    function [CREDIT_W-1:0] fpc_scale;
        input [FRAC_W+7:0] m;
        input [1:0] mode;
        reg [63:0] w;
        begin
            w = {{(64-FRAC_W-8){1'b0}}, m};
            case (mode)
                2'h0: w = (w * 64'd524288) / 64'd514500;
                2'h1: w = (w * 64'd512) / 64'd500;
                2'h2: w = (w * 64'd1024) / 64'd1029;
                default: w = w;
            endcase
            fpc_scale = w[CREDIT_W-1:0];
        end
    endfunction

    assign eff = fpc_scale(mult_i, mode_i);
    assign thr = {{(CREDIT_W-FRAC_W-8){1'b0}}, div_i, {FRAC_W{1'b0}}};
    assign sum = credit + (ref_tick_i ? eff : {CREDIT_W{1'b0}});

    // one output tick per cycle at most; surplus credit waits for the next cycle
    always @* begin
        next_credit = sum;
        next_tick = 1'b0;
        if (!run_i) begin
            next_credit = {CREDIT_W{1'b0}};
        end else if ((div_i != 8'h00) && (credit >= thr)) begin
            next_credit = sum - thr;
            next_tick = 1'b1;
        end
    end

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            credit <= {CREDIT_W{1'b0}};
            tick_o <= 1'b0;
        end else begin
            credit <= next_credit;
            tick_o <= next_tick;
        end
    end
endmodule

// ===== verif/fpc_top_asserts.sv
// port-level assertion checker for the fractional pll clock control
`timescale 1ns/1ps
`include "fpc_map.vh"
module fpc_top_asserts #(
    parameter SETTLE_CYCLES = 20
) (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    input wire ref_clk_i,
    input wire mclk_en_o,
    input wire pll_power_o,
    input wire [7:0] cal_ratio_o,
    input wire pll_settled_o
);
    // ----------------------------------------------------------------
    // shadow of the source select, and cycles spent powered
    // ----------------------------------------------------------------
    reg src_q;
    reg [15:0] pwr_cnt;
    wire ctrl_wr = wr_i && addr_i == `FPC_ADDR_CTRL;
    wire cal_wr = wr_i && addr_i == `FPC_ADDR_CAL;
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            src_q <= 1'b0;
            pwr_cnt <= 16'h0000;
        end else begin
            if (ctrl_wr) begin
                src_q <= wdata_i[0];
            end
            pwr_cnt <= pll_power_o ? pwr_cnt + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    power_on_a: assert property (ctrl_wr && wdata_i[1] ##1 !ctrl_wr |=> pll_power_o)
        else $error("power did not follow start");
    power_off_a: assert property (ctrl_wr && !wdata_i[1] ##1 !ctrl_wr |=> !pll_power_o)
        else $error("power stayed on after stop");
    settle_drop_a: assert property ($fell(pll_power_o) |=> !pll_settled_o)
        else $error("settled flag outlived power");
    settle_time_a: assert property ($rose(pll_settled_o) |->
        pwr_cnt >= SETTLE_CYCLES - 1 && pwr_cnt <= SETTLE_CYCLES + 1)
        else $error("settle wait has wrong length");
    hold_mclk_a: assert property ((src_q && !pll_settled_o) [*6] |-> !mclk_en_o)
        else $error("master clock ticked before settling");
    cal_out_a: assert property (cal_wr ##1 !cal_wr |=> cal_ratio_o == $past(wdata_i, 2))
        else $error("calibration output wrong");
    status_rd_a: assert property (rd_i && addr_i == `FPC_ADDR_STATUS |=>
        rdata_o[1:0] == {pll_power_o, pll_settled_o})
        else $error("status disagrees with outputs");
    bypass_gap_a: assert property (!src_q && mclk_en_o |=> !mclk_en_o)
        else $error("bypass ticks faster than reference");
    cover property ($rose(pll_settled_o));
    cover property (!src_q && mclk_en_o);
    cover property (src_q && pll_settled_o && mclk_en_o);
endmodule
bind fpc_top fpc_top_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .ref_clk_i(ref_clk_i), .mclk_en_o(mclk_en_o), .pll_power_o(pll_power_o),
    .cal_ratio_o(cal_ratio_o), .pll_settled_o(pll_settled_o));

// ===== verif/fpc_ref_model.sv
// reference clock source driving the shared bit clock pin
`timescale 1ns/1ps
module fpc_ref_model #(
    parameter HALF_NS = 500
) (
    input wire run_i,
    output reg ref_o
);
    // stands low when stopped, as an idle bit clock would
    initial ref_o = 1'b0;
    always #(HALF_NS) ref_o = run_i ? ~ref_o : 1'b0;
endmodule

// ===== verif/fpc_top_tb.sv
// self-checking testbench for the fractional pll clock control
`timescale 1ns/1ps
`include "fpc_map.vh"
module fpc_top_tb;
    localparam S = 20;
    reg sys_clk_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg [7:0] addr_i = 8'h00;
    reg [7:0] wdata_i = 8'h00;
    reg wr_i = 1'b0;
    reg rd_i = 1'b0;
    wire [7:0] rdata_o;
    wire [7:0] cal_ratio_o;
    wire ref_clk_i;
    wire mclk_en_o;
    wire pll_power_o;
    wire pll_settled_o;
    integer n_fail = 0;
    integer n_checks = 0;
    integer k;
    integer n;
    logic [7:0] rv [0:10] = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h03, 8'h10, 8'h80, 8'h00, 8'h00};
    logic [7:0] mk [0:10] = '{8'h00, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'h00, 8'h00};
    always #50 sys_clk_i = ~sys_clk_i;
    fpc_ref_model #(.HALF_NS(500)) ref_src (.run_i(1'b1), .ref_o(ref_clk_i));
    // short settle count keeps the run brief
    fpc_top #(.SETTLE_CYCLES(S), .TIMER_W(16)) uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .ref_clk_i(ref_clk_i), .mclk_en_o(mclk_en_o), .pll_power_o(pll_power_o),
        .cal_ratio_o(cal_ratio_o), .pll_settled_o(pll_settled_o));
    // ----------------------------------------------------------------
    // bus and check tasks
    // ----------------------------------------------------------------
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_fail);
            if (n_fail == 0 && n_checks > 0) begin
                $display("Regression OK");
            end else begin
                $display("Regression broken");
            end
            $finish;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge sys_clk_i);
            addr_i <= a;
            wdata_i <= d;
            wr_i <= 1'b1;
            @(posedge sys_clk_i);
            wr_i <= 1'b0;
        end
    endtask
    task rchk(input [7:0] a, input [7:0] e);
        begin
            @(posedge sys_clk_i);
            addr_i <= a;
            rd_i <= 1'b1;
            @(posedge sys_clk_i);
            rd_i <= 1'b0;
            #1 chk({24'h0, rdata_o}, {24'h0, e});
        end
    endtask
    task count(output integer t);
        integer i;
        begin
            t = 0;
            for (i = 0; i < 4000; i = i + 1) begin
                @(posedge sys_clk_i);
                #1 t = t + (mclk_en_o === 1'b1);
            end
        end
    endtask
    // window edges cost at most one tick either way
    task near(input integer seen, input real e);
        integer r;
        begin
            r = $rtoi(e + 0.5);
            chk(seen, (seen >= r - 1 && seen <= r + 1) ? seen : r);
        end
    endtask
    task pll_run(input [1:0] pc, input [7:0] mi, input [7:0] fh, input [1:0] md, input [7:0] dv);
        integer c;
        real e;
        begin
            wr(`FPC_ADDR_PREDIV, {6'h00, pc});
            wr(`FPC_ADDR_DIVOUT, {dv[6:0], 1'b0});
            wr(`FPC_ADDR_FRAC_LO, 8'h00);
            wr(`FPC_ADDR_FRAC_MID, 8'h00);
            wr(`FPC_ADDR_FRAC_HI, fh);
            wr(`FPC_ADDR_INT, mi);
            wr(`FPC_ADDR_MODE, {6'h00, md});
            wr(`FPC_ADDR_CAL, 8'h60);
            wr(`FPC_ADDR_CTRL, 8'h03);
            c = 0;
            while (pll_settled_o !== 1'b1 && c < 200) begin
                @(posedge sys_clk_i);
                #1 c = c + 1;
            end
            chk(c, S + 1);
            if (c == 200) test_done;
            wr(`FPC_ADDR_DIVOUT, dv);
            repeat (20 << pc) @(posedge sys_clk_i);
            count(c);
            e = 400.0 / (1 << pc) * (mi + fh / 256.0) / dv;
            if (!md[1]) e = e * 512.0 / 500.0;
            if (!md[0]) e = e * 1024.0 / 1029.0;
            near(c, e);
            wr(`FPC_ADDR_CTRL, 8'h01);
            repeat (4) @(posedge sys_clk_i);
            chk({31'h0, pll_power_o}, 32'h0);
            rchk(`FPC_ADDR_STATUS, 8'h00);
        end
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        chk({24'h0, cal_ratio_o}, 32'h80);
        for (k = 0; k < 11; k = k + 1) begin
            rchk(k[7:0], rv[k]);
        end
        for (k = 1; k < 11; k = k + 1) begin
            wr(k[7:0], 8'hFF);
            rchk(k[7:0], mk[k]);
        end
        chk({24'h0, cal_ratio_o}, 32'hFF);
        wr(`FPC_ADDR_CTRL, 8'h00);
        count(n);
        near(n, 400.0);
        chk({31'h0, pll_power_o}, 32'h0);
        pll_run(2'h0, 8'h08, 8'h00, 2'h3, 8'h08);
        pll_run(2'h1, 8'h10, 8'h00, 2'h3, 8'h08);
        pll_run(2'h2, 8'h20, 8'h00, 2'h3, 8'h08);
        pll_run(2'h3, 8'h50, 8'h00, 2'h3, 8'h10);
        pll_run(2'h0, 8'h02, 8'h80, 2'h3, 8'h02);
        for (k = 0; k < 3; k = k + 1) begin
            pll_run(2'h0, 8'h08, 8'h00, k[1:0], 8'h08);
        end
        test_done;
    end
endmodule
